//--- dv/tsviu_chk.sv
// Port-level assertions for the interrupt unit.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module tsviu_chk #(
    parameter ADDR_W = 7,
    parameter PC_W   = 11
) (
    input wire              ref_clk_i, rst_n_i, ext_irq_n_i,
    input wire              timer_overflow_i, conv_done_i,
    input wire              second_phase_pulse_i, stack_full_i,
    input wire              power_down_i, return_from_service_i,
    input wire              return_from_subroutine_i,
    input wire [ADDR_W-1:0] mem_addr_i,
    input wire              mem_wr_i, mem_rd_i,
    input wire [7:0]        mem_wdata_i, mem_rdata_o,
    input wire              mem_sel_o, irq_call_o,
    input wire [PC_W-1:0]   irq_vector_o,
    input wire              push_pc_o, wake_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire rd_hit = mem_rd_i && mem_addr_i == 7'h0B;
    sequence s_wr; mem_wr_i && mem_addr_i == 7'h0B; endsequence
    sequence s_rd; !mem_wr_i ##1 rd_hit; endsequence
    // Source enable bits 1 to 3 are never touched by hardware
    a_enable_readback: assert property (s_wr ##1 s_rd |=>
        (mem_rdata_o & 8'h0E) == ($past(mem_wdata_i, 3) & 8'h0E))
        else $error("enable bits not read back");
    a_rd_answer: assert property (rd_hit |=> mem_sel_o)
        else $error("no read answer");
    a_rd_refused: assert property (mem_rd_i && !rd_hit |=>
        !mem_sel_o && mem_rdata_o == 8'h00) else $error("bad unmapped read");
    a_call_pushes: assert property (irq_call_o == push_pc_o)
        else $error("call without push");
    a_call_on_pulse: assert property (irq_call_o |->
        $past(second_phase_pulse_i)) else $error("call off phase");
    a_call_not_full: assert property (irq_call_o |->
        !$past(stack_full_i)) else $error("call with full stack");
    a_call_single: assert property (irq_call_o |=> !irq_call_o)
        else $error("double call");
    a_vector_legal: assert property (irq_call_o |->
        irq_vector_o inside {11'h004, 11'h008, 11'h00C})
        else $error("bad vector");
    a_vector_holds: assert property (!irq_call_o |->
        $stable(irq_vector_o)) else $error("vector moved");
    a_wake_halted: assert property (wake_o |-> $past(power_down_i))
        else $error("wake while running");
endmodule
bind tsviu_top tsviu_chk #(.ADDR_W(ADDR_W), .PC_W(PC_W)) chk_u (.*);

//--- dv/tsviu_seq_model.sv
// Sequencer stand-in: phase pulse every 4 cycles and a return stack.
// Assumes push and pop pulses last one system clock each.
`timescale 1ns/1ns
module tsviu_seq_model #(
    parameter LEVELS = 6
) (
    input  wire ref_clk_i,
    input  wire rst_n_i,
    input  wire push_i,
    input  wire pop_i,
    output reg  phase_o,
    output wire full_o
);
    reg [1:0] div_q;
    reg [2:0] depth_q;
    // Small depth lets the bench reach a full stack quickly
    assign full_o = depth_q == LEVELS;
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            div_q   <= 2'h0;
            depth_q <= 3'h0;
            phase_o <= 1'b0;
        end else begin
            div_q   <= div_q + 2'h1;
            phase_o <= div_q == 2'h3;
            if (push_i && depth_q != LEVELS) begin
                depth_q <= depth_q + 3'h1;
            end else if (pop_i && depth_q != 3'h0) begin
                depth_q <= depth_q - 3'h1;
            end
        end
    end
endmodule

//--- dv/tsviu_tb.sv
// Self-checking bench for the interrupt unit.
// Assumes the sequencer model runs a one-level stack.
`timescale 1ns/1ns
module testbench;
    reg ref_clk_i = 0, rst_n_i = 0, ext_irq_n_i = 1, power_down_i = 0;
    reg timer_overflow_i = 0, conv_done_i = 0, mem_wr_i = 0, mem_rd_i = 0;
    reg return_from_service_i = 0, return_from_subroutine_i = 0;
    reg [6:0] mem_addr_i = 7'h00;
    reg [7:0] mem_wdata_i = 8'h00;
    wire second_phase_pulse_i, stack_full_i, mem_sel_o, irq_call_o;
    wire push_pc_o, wake_o;
    wire [7:0] mem_rdata_o;
    wire [10:0] irq_vector_o;
    integer error_cnt = 0, n_tests = 0, cyc = 0, i;
    tsviu_top dut_u (.ref_clk_i, .rst_n_i, .ext_irq_n_i, .timer_overflow_i,
        .conv_done_i, .second_phase_pulse_i, .stack_full_i, .power_down_i,
        .return_from_service_i, .return_from_subroutine_i, .mem_addr_i,
        .mem_wr_i, .mem_rd_i, .mem_wdata_i, .mem_rdata_o, .mem_sel_o,
        .irq_call_o, .irq_vector_o, .push_pc_o, .wake_o);
    tsviu_seq_model #(.LEVELS(1)) seq_u (.ref_clk_i, .rst_n_i,
        .push_i(push_pc_o), .phase_o(second_phase_pulse_i),
        .pop_i(return_from_service_i | return_from_subroutine_i),
        .full_o(stack_full_i));
    initial forever #50 ref_clk_i = ~ref_clk_i;
    task summarize;
        if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            summarize;
        end
    end
    task chk(input string nm, input [10:0] e, input [10:0] g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input [7:0] d);
        @(posedge ref_clk_i);
        mem_wr_i <= 1; mem_addr_i <= 7'h0B; mem_wdata_i <= d;
        @(posedge ref_clk_i);
        mem_wr_i <= 0;
    endtask
    task rd(input [6:0] a, input [7:0] e);
        @(posedge ref_clk_i);
        mem_rd_i <= 1; mem_addr_i <= a;
        @(posedge ref_clk_i);
        mem_rd_i <= 0;
        #1 chk("rdata", {3'h0, e}, {3'h0, mem_rdata_o});
        chk("sel", {10'h000, a == 7'h0B}, {10'h000, mem_sel_o});
    endtask
    task ev(input t, input c);
        @(posedge ref_clk_i);
        timer_overflow_i <= t; conv_done_i <= c;
        @(posedge ref_clk_i);
        timer_overflow_i <= 0; conv_done_i <= 0;
    endtask
    task ret(input svc);
        @(posedge ref_clk_i);
        return_from_service_i <= svc; return_from_subroutine_i <= !svc;
        @(posedge ref_clk_i);
        return_from_service_i <= 0; return_from_subroutine_i <= 0;
    endtask
    task wait_call(input [10:0] v);
        #1;
        for (i = 0; i < 12 && irq_call_o !== 1'b1; i = i + 1)
            @(posedge ref_clk_i) #1;
        chk("call", 11'h001, {10'h000, irq_call_o});
        chk("vector", v, irq_vector_o);
    endtask
    task no_call;
        for (i = 0; i < 12; i = i + 1)
            @(posedge ref_clk_i) #1 chk("idle", 11'h000, {10'h000, irq_call_o});
    endtask
    task t_regs;
        wr(8'h0E); rd(7'h0B, 8'h0E);
        rd(7'h0C, 8'h00);
    endtask
    task t_timer;
        wr(8'h05); ev(1, 0); wait_call(11'h008);
        rd(7'h0B, 8'h04);
        ret(0); rd(7'h0B, 8'h04);
        ret(1); rd(7'h0B, 8'h05);
    endtask
    task t_prio;
        wr(8'h0E); ev(1, 1);
        @(posedge ref_clk_i) ext_irq_n_i <= 0;
        no_call; rd(7'h0B, 8'h7E);
        wr(8'h7F); wait_call(11'h004);
        rd(7'h0B, 8'h6E);
        ret(1); wait_call(11'h008);
        ret(1); wait_call(11'h00C);
        @(posedge ref_clk_i) ext_irq_n_i <= 1;
    endtask
    task t_full;
        ev(1, 0); wr(8'h25); no_call;
        ret(0); wait_call(11'h008);
        ret(1); wr(8'h00);
    endtask
    task t_wake;
        @(posedge ref_clk_i) power_down_i <= 1;
        ev(0, 1);
        #1;
        for (i = 0; i < 6 && wake_o !== 1'b1; i = i + 1)
            @(posedge ref_clk_i) #1;
        chk("wake", 11'h001, {10'h000, wake_o});
        @(posedge ref_clk_i) power_down_i <= 0;
    endtask
    task t_mask;
        wr(8'h41); no_call;
        rd(7'h0B, 8'h41);
        @(posedge ref_clk_i);
        mem_wr_i <= 1; mem_addr_i <= 7'h0B; mem_wdata_i <= 8'h00;
        timer_overflow_i <= 1;
        @(posedge ref_clk_i);
        mem_wr_i <= 0; timer_overflow_i <= 0;
        rd(7'h0B, 8'h20);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_n_i <= 1;
        t_regs; t_timer; t_prio; t_full; t_wake; t_mask;
        summarize;
    end
endmodule

//--- hw/tsviu_consts.vh
// Constants for the three-source vectored interrupt unit.
// Assumes inclusion by bare name from design files under hw/.
`ifndef TSVIU_CONSTS_VH
`define TSVIU_CONSTS_VH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define TSVIU_CTRL_ADDR      7'h0B
`define TSVIU_CTRL_RESET     8'h00

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define TSVIU_BIT_MASTER     0
`define TSVIU_BIT_EXT_EN     1
`define TSVIU_BIT_TMR_EN     2
`define TSVIU_BIT_CONV_EN    3
`define TSVIU_BIT_EXT_PEND   4
`define TSVIU_BIT_TMR_PEND   5
`define TSVIU_BIT_CONV_PEND  6
`define TSVIU_BIT_TEST       7

// ------------------------------------------------------------
// Vectors
// ------------------------------------------------------------
`define TSVIU_VEC_EXT        11'h004
`define TSVIU_VEC_TMR        11'h008
`define TSVIU_VEC_CONV       11'h00C
`define TSVIU_VEC_NONE       11'h000

`endif

//--- hw/tsviu_sync_fall.v
// Two-flop synchroniser with falling-edge detector.
// Assumes an asynchronous level input and one system clock.
`timescale 1ns/1ns
module tsviu_sync_fall (
    // Clock and reset
    input  wire ref_clk_i,
    input  wire rst_n_i,
    // Asynchronous level in, edge pulse out
    input  wire async_i,
    output reg  fall_o
);

    reg meta_q;
    reg sync_q;
    reg last_q;

    // Inputs idle high so reset values avoid a false edge
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
            fall_o <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            last_q <= sync_q;
            fall_o <= last_q & ~sync_q;
        end
    end

endmodule

//--- hw/tsviu_top.v
// Interrupt control register, request latching, priority and vectoring.
// Assumes sequencer gives one-cycle pulses on the system clock and
// holds the data-memory bus for one cycle per access.
`timescale 1ns/1ns
`include "tsviu_consts.vh"

module tsviu_top #(
    parameter ADDR_W = 7,
    parameter PC_W   = 11
) (
    // Clock and reset
    input  wire              ref_clk_i,
    input  wire              rst_n_i,
    // External pin, active low
    input  wire              ext_irq_n_i,
    // Peripheral events, one-cycle pulses
    input  wire              timer_overflow_i,
    input  wire              conv_done_i,
    // Sequencer timing and stack state
    input  wire              second_phase_pulse_i,
    input  wire              stack_full_i,
    input  wire              power_down_i,
    input  wire              return_from_service_i,
    input  wire              return_from_subroutine_i,
    // Data-memory access
    input  wire [ADDR_W-1:0] mem_addr_i,
    input  wire              mem_wr_i,
    input  wire              mem_rd_i,
    input  wire [7:0]        mem_wdata_i,
    output reg  [7:0]        mem_rdata_o,
    output reg               mem_sel_o,
    // Service request to sequencer
    output reg               irq_call_o,
    output reg  [PC_W-1:0]   irq_vector_o,
    output reg               push_pc_o,
    output reg               wake_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    reg        master_irq_enable_q;
    reg        ext_irq_enable_q;
    reg        timer_irq_enable_q;
    reg        conv_irq_enable_q;
    reg        ext_irq_pending_q;
    reg        timer_irq_pending_q;
    reg        conv_irq_pending_q;
    // Hardware both sets and clears master and pending bits;
    // enable bits change by software writes alone
    reg        test_bit_q;
    reg        halt_q;
    reg [2:0]  pend_at_halt_q;

    wire       ext_fall;
    reg        ack_ext;
    reg        ack_tmr;
    reg        ack_conv;
    reg        any_ack;
    reg [PC_W-1:0] vec_d;
    wire       reg_hit;
    wire       reg_wr;
    wire [7:0] ctrl_view;

    // ------------------------------------------------------------
    // External pin conditioning
    // ------------------------------------------------------------
    tsviu_sync_fall u_ext_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (ext_irq_n_i),
        .fall_o    (ext_fall)
    );

    assign reg_hit = (mem_addr_i == `TSVIU_CTRL_ADDR);
    assign reg_wr  = reg_hit & mem_wr_i;
    assign ctrl_view = {test_bit_q, conv_irq_pending_q,
                        timer_irq_pending_q, ext_irq_pending_q,
                        conv_irq_enable_q, timer_irq_enable_q,
                        ext_irq_enable_q, master_irq_enable_q};

    // ------------------------------------------------------------
    // Acknowledge decision
    // ------------------------------------------------------------
    // Decision taken only on second-phase pulse; flags seen here
    // include everything latched since the previous pulse.
    // Stack-full check holds a request back without
    // touching its flag, so it is served after a pop
    always @* begin
        ack_ext  = 1'b0;
        ack_tmr  = 1'b0;
        ack_conv = 1'b0;
        vec_d    = `TSVIU_VEC_NONE;
        if (second_phase_pulse_i && master_irq_enable_q
            && !stack_full_i) begin
            if (ext_irq_pending_q && ext_irq_enable_q) begin
                ack_ext = 1'b1;
                vec_d   = `TSVIU_VEC_EXT;
            end else if (timer_irq_pending_q
                         && timer_irq_enable_q) begin
                ack_tmr = 1'b1;
                vec_d   = `TSVIU_VEC_TMR;
            end else if (conv_irq_pending_q
                         && conv_irq_enable_q) begin
                ack_conv = 1'b1;
                vec_d    = `TSVIU_VEC_CONV;
            end
        end
        any_ack = ack_ext | ack_tmr | ack_conv;
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Event set of pending bits after software write and acknowledge clear
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            {test_bit_q, conv_irq_pending_q, timer_irq_pending_q,
             ext_irq_pending_q, conv_irq_enable_q,
             timer_irq_enable_q, ext_irq_enable_q,
             master_irq_enable_q} <= `TSVIU_CTRL_RESET;
        end else begin
            if (reg_wr) begin
                master_irq_enable_q <= mem_wdata_i[`TSVIU_BIT_MASTER];
                ext_irq_enable_q    <= mem_wdata_i[`TSVIU_BIT_EXT_EN];
                timer_irq_enable_q  <= mem_wdata_i[`TSVIU_BIT_TMR_EN];
                conv_irq_enable_q   <= mem_wdata_i[`TSVIU_BIT_CONV_EN];
                ext_irq_pending_q   <= mem_wdata_i[`TSVIU_BIT_EXT_PEND];
                timer_irq_pending_q <= mem_wdata_i[`TSVIU_BIT_TMR_PEND];
                conv_irq_pending_q  <= mem_wdata_i[`TSVIU_BIT_CONV_PEND];
                // Stored only; software is expected to keep it zero
                test_bit_q          <= mem_wdata_i[`TSVIU_BIT_TEST];
            end
            // Plain subroutine return is accepted but ignored:
            // it must leave the master enable as it stands
            if (return_from_service_i)
                master_irq_enable_q <= 1'b1;
            if (any_ack)
                master_irq_enable_q <= 1'b0;
            if (ack_ext)
                ext_irq_pending_q <= 1'b0;
            if (ack_tmr)
                timer_irq_pending_q <= 1'b0;
            if (ack_conv)
                conv_irq_pending_q <= 1'b0;
            // Latched regardless of enables; held until cleared
            if (ext_fall)
                ext_irq_pending_q <= 1'b1;
            if (timer_overflow_i)
                timer_irq_pending_q <= 1'b1;
            if (conv_done_i)
                conv_irq_pending_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Power-down wake
    // ------------------------------------------------------------
    // A flag already set at halt entry does not wake again.
    // Wake is a hint only; the sequencer owns the
    // start-up delay and any resumption
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            halt_q         <= 1'b0;
            pend_at_halt_q <= 3'h0;
            wake_o         <= 1'b0;
        end else begin
            halt_q <= power_down_i;
            if (power_down_i && !halt_q)
                pend_at_halt_q <= {conv_irq_pending_q,
                                   timer_irq_pending_q,
                                   ext_irq_pending_q};
            wake_o <= power_down_i && halt_q &&
                      ((ext_fall & ~pend_at_halt_q[0]) |
                       (timer_overflow_i & ~pend_at_halt_q[1]) |
                       (conv_done_i & ~pend_at_halt_q[2]));
        end
    end

    // ------------------------------------------------------------
    // Outputs to sequencer and data bus
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            irq_call_o   <= 1'b0;
            push_pc_o    <= 1'b0;
            irq_vector_o <= `TSVIU_VEC_NONE;
            mem_rdata_o  <= 8'h00;
            mem_sel_o    <= 1'b0;
        end else begin
            irq_call_o <= any_ack;
            // Only the program counter is saved; status is software's
            push_pc_o  <= any_ack;
            if (any_ack)
                irq_vector_o <= vec_d;
            // Read data is zero off the register so a shared
            // bus can OR several responders together
            mem_sel_o   <= reg_hit & mem_rd_i;
            mem_rdata_o <= (reg_hit & mem_rd_i) ? ctrl_view : 8'h00;
        end
    end

endmodule
